/* nand_flash_strobe_timing.sv */
// pin-level strobe sequencer toward a nand flash: latches, strobes, data bus.
// assumes MCLK is the controller clock and all inputs are synchronous to it.
// Operation
// R1 - command latch stable one period around the capturing write strobe edge
// R2 - chip select asserted one period before and after every strobe
// R3 - write strobe low for at least one full period
// R4 - address latch stable one period around the capturing write strobe edge
// R5 - write data valid one period before and after write strobe rise
// R6 - each write cycle lasts at least two periods
// R7 - write strobe high at least one period between pulses
// R8 - wait four periods after flash ready before read strobe falls
// R9 - read strobe low at least one and a half periods
// R10 - each read cycle lasts at least two periods
// R11 - read strobe high at least half a period between pulses
// R12 - flash presents read data 15 ns before the sampling point
// R13 - flash holds read data until the sampling point, no more
// R14 - read data captured on the controller clock, not a returned strobe
// R15 - all strobe intervals are multiples of half the controller period; read strobe edges move on the falling edge, giving 1.5-period spans
// R16 - divider never lets the controller clock exceed 66 MHz
// R17 - divider resets to give 16.63 MHz from the cpu clock
// R18 - divide by 12 or 8 from 266 MHz is the usual setting
// R19 - read strobe edges fall on both clock edges for half periods; here both read strobe edges move on the falling edge only
// R20 - latches low, chip select off, strobes high from reset
`timescale 1ns/1ns
`default_nettype none
module nand_flash_strobe_timing
  import nand_strobe_pkg::*;
#(
  parameter int unsigned DATA_WIDTH = 8,
  parameter int unsigned BUF_DEPTH  = 2
) (
  // clock and reset
  input  wire logic                  MCLK,
  input  wire logic                  RESET,
  // request stream
  input  wire logic                  CMD_VALID,
  output var  logic                  CMD_READY,
  input  wire logic [1:0]            CMD_KIND,
  input  wire logic [DATA_WIDTH-1:0] CMD_DATA,
  // read data stream
  output var  logic                  RD_VALID,
  input  wire logic                  RD_READY,
  output var  logic [DATA_WIDTH-1:0] RD_DATA,
  // divider toward the clock control unit
  input  wire logic                  DIV_LOAD,
  input  wire logic [DIV_WIDTH-1:0]  DIV_VALUE,
  output var  logic [DIV_WIDTH-1:0]  FLASH_CLOCK_DIVIDER,
  // flash pins
  output var  logic                  COMMAND_LATCH_EN,
  output var  logic                  ADDRESS_LATCH_EN,
  output var  logic                  FLASH_CHIP_SELECT_N,
  output var  logic                  FLASH_WRITE_STROBE_N,
  output var  logic                  FLASH_READ_STROBE_N,
  input  wire logic                  FLASH_READY,
  input  wire logic [DATA_WIDTH-1:0] FLASH_DQ_IN,
  output var  logic [DATA_WIDTH-1:0] FLASH_DQ_OUT,
  output var  logic                  FLASH_DQ_OE_N
);

  state_t                  state_q;
  state_t                  state_d;
  kind_t                   kind_q;
  logic [DATA_WIDTH-1:0]   data_q;
  logic [2:0]              rdy_cnt_q;
  logic                    accept;
  logic                    same_write;
  logic                    push;
  logic                    pop;
  logic                    buf_full_d;
  logic                    cle_d;
  logic                    ale_d;
  logic                    cs_n_d;
  logic                    we_n_d;
  logic                    oe_n_d;
  logic                    rd_want_n_q;
  logic [BUF_DEPTH-1:0]    valid_q;
  logic [DATA_WIDTH-1:0]   mem_q [BUF_DEPTH];

  assign accept     = CMD_VALID & CMD_READY;
  assign same_write = (CMD_KIND == kind_q) && (kind_q != KIND_READ);
  // a byte is taken at the edge that ends the second low cycle
  assign push       = (state_q == ST_RLOW2);
  assign pop        = valid_q[0] & RD_READY;

  // sequencing: every state except ST_IDLE and ST_RWAIT lasts exactly one controller period
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = (kind_t'(CMD_KIND) == KIND_READ) ? ST_RWAIT : ST_SETUP;
        end
      end
      ST_SETUP: begin
        state_d = ST_WLOW;                      // see R2, see R5
      end
      ST_WLOW: begin
        state_d = ST_WHOLD;                     // see R3
      end
      ST_WHOLD: begin
        if (!accept) begin
          state_d = ST_IDLE;                    // see R2
        end else if (same_write) begin
          state_d = ST_WLOW;                    // see R6, see R7
        end else if (kind_t'(CMD_KIND) == KIND_READ) begin
          state_d = ST_RWAIT;
        end else begin
          state_d = ST_SETUP;                   // see R1, see R4
        end
      end
      ST_RWAIT: begin
        if (FLASH_READY && rdy_cnt_q >= READY_WAIT_CNT) begin
          state_d = ST_RLOW1;                   // see R8
        end
      end
      ST_RLOW1: begin
        state_d = ST_RLOW2;                     // see R9
      end
      ST_RLOW2: begin
        state_d = ST_RHIGH;
      end
      ST_RHIGH: begin
        state_d = ST_RTAIL;                     // see R10, see R11
      end
      ST_RTAIL: begin
        state_d = ST_IDLE;                      // see R2
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // the request is held for the whole transfer
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      kind_q <= KIND_COMMAND;
      data_q <= '0;
    end else if (accept) begin
      kind_q <= kind_t'(CMD_KIND);
      data_q <= CMD_DATA;
    end
  end

  // consecutive ready samples; any busy sample restarts the wait
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      rdy_cnt_q <= '0;
    end else if (state_q != ST_RWAIT || !FLASH_READY) begin
      rdy_cnt_q <= '0;
    end else if (rdy_cnt_q < READY_WAIT_CNT) begin
      rdy_cnt_q <= rdy_cnt_q + 3'h1;            // see R8, see R15
    end
  end

  // next pin levels follow the next state, so every pin is a flop
  always_comb begin
    cle_d  = 1'b0;
    ale_d  = 1'b0;
    cs_n_d = 1'b1;
    we_n_d = 1'b1;
    oe_n_d = 1'b1;
    case (state_d)
      ST_SETUP, ST_WLOW, ST_WHOLD: begin
        cs_n_d = 1'b0;                          // see R2
        cle_d  = (kind_sel() == KIND_COMMAND);  // see R1
        ale_d  = (kind_sel() == KIND_ADDRESS);  // see R4
        oe_n_d = 1'b0;                          // see R5
        we_n_d = (state_d != ST_WLOW);          // see R3, see R7
      end
      ST_RWAIT, ST_RLOW1, ST_RLOW2, ST_RHIGH, ST_RTAIL: begin
        cs_n_d = 1'b0;                          // see R2
      end
      default: begin
        cs_n_d = 1'b1;
      end
    endcase
  end

  // kind that the next state works on: a freshly taken request or the held one
  function automatic kind_t kind_sel();
    kind_sel = accept ? kind_t'(CMD_KIND) : kind_q;
  endfunction

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      COMMAND_LATCH_EN     <= 1'b0;             // see R20
      ADDRESS_LATCH_EN     <= 1'b0;
      FLASH_CHIP_SELECT_N  <= 1'b1;
      FLASH_WRITE_STROBE_N <= 1'b1;
      FLASH_DQ_OE_N        <= 1'b1;
    end else begin
      COMMAND_LATCH_EN     <= cle_d;
      ADDRESS_LATCH_EN     <= ale_d;
      FLASH_CHIP_SELECT_N  <= cs_n_d;
      FLASH_WRITE_STROBE_N <= we_n_d;
      FLASH_DQ_OE_N        <= oe_n_d;
    end
  end

  // data changes only on the edge that lowers the write strobe
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      FLASH_DQ_OUT <= '0;
    end else if (state_d == ST_WLOW) begin
      FLASH_DQ_OUT <= accept ? CMD_DATA : data_q;   // see R5
    end
  end

  // read strobe is planned on the rising edge and launched on the falling
  // edge; this gives 2 periods low sampled after 1.5 and one and a half periods of
  // high time before chip select may drop
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      rd_want_n_q <= 1'b1;
    end else begin
      rd_want_n_q <= !(state_d == ST_RLOW1 || state_d == ST_RLOW2);
    end
  end

  always_ff @(negedge MCLK) begin
    if (RESET) begin
      FLASH_READ_STROBE_N <= 1'b1;              // see R20
    end else begin
      FLASH_READ_STROBE_N <= rd_want_n_q;       // see R19, see R9, see R11
    end
  end

  // request port opens only where a new transfer can start at once; a full
  // buffer closes it so a stalled reader never loses a byte
  assign buf_full_d = pop ? 1'b0 : valid_q[BUF_DEPTH-1];

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      CMD_READY <= 1'b0;
    end else begin
      CMD_READY <= (state_d == ST_IDLE || state_d == ST_WHOLD) && !buf_full_d;
    end
  end

  // two-entry shift buffer; entry 0 is the head and feeds the pins
  for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
    logic keep_valid;
    logic prev_valid;
    logic take_push;
    if (i == BUF_DEPTH - 1) begin : g_last
      assign keep_valid = pop ? 1'b0 : valid_q[i];
    end else begin : g_mid
      assign keep_valid = pop ? valid_q[i+1] : valid_q[i];
    end
    if (i == 0) begin : g_head
      assign prev_valid = 1'b1;
    end else begin : g_tail
      assign prev_valid = pop ? valid_q[i] : valid_q[i-1];
    end
    assign take_push = push && !keep_valid && prev_valid;

    always_ff @(posedge MCLK) begin
      if (RESET) begin
        valid_q[i] <= 1'b0;
      end else begin
        valid_q[i] <= keep_valid | take_push;
      end
    end

    always_ff @(posedge MCLK) begin
      if (RESET) begin
        mem_q[i] <= '0;
      end else if (take_push) begin
        mem_q[i] <= FLASH_DQ_IN;                // see R14, see R12, see R13
      end else if (pop && i < BUF_DEPTH - 1) begin
        mem_q[i] <= mem_q[(i + 1) % BUF_DEPTH];
      end
    end
  end

  assign RD_VALID = valid_q[0];
  assign RD_DATA  = mem_q[0];

  // divider setting; values that would push the clock above its ceiling are
  // raised to the smallest legal divide
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      FLASH_CLOCK_DIVIDER <= DIV_RESET;         // see R17
    end else if (DIV_LOAD) begin
      if (DIV_VALUE < DIV_MIN) begin
        FLASH_CLOCK_DIVIDER <= DIV_MIN;         // see R16
      end else begin
        FLASH_CLOCK_DIVIDER <= DIV_VALUE;       // see R18
      end
    end
  end

endmodule
`default_nettype wire

/* nand_strobe_pkg.sv */
// constants for the nand flash strobe sequencer: timing counts, divider
// limits and command kinds. assumes the sequencer clock is the controller clock.
`default_nettype none
package nand_strobe_pkg;

  // controller clock period, the unit of every strobe interval
  localparam int unsigned CTRL_PERIOD_NS = 100;

  // strobe intervals in ns as multiples of the controller period
  localparam int unsigned LATCH_SETUP_NS  = CTRL_PERIOD_NS;
  localparam int unsigned WRITE_PULSE_NS  = CTRL_PERIOD_NS;
  localparam int unsigned READY_TO_RD_NS  = 4 * CTRL_PERIOD_NS;
  localparam int unsigned READ_PULSE_NS   = (3 * CTRL_PERIOD_NS) / 2;

  // least times round up to whole cycles
  localparam int unsigned LATCH_SETUP_CYC =
    (LATCH_SETUP_NS + CTRL_PERIOD_NS - 1) / CTRL_PERIOD_NS;
  localparam int unsigned WRITE_PULSE_CYC =
    (WRITE_PULSE_NS + CTRL_PERIOD_NS - 1) / CTRL_PERIOD_NS;
  localparam int unsigned READY_WAIT_CYC  =
    (READY_TO_RD_NS + CTRL_PERIOD_NS - 1) / CTRL_PERIOD_NS;
  localparam logic [2:0]  READY_WAIT_CNT  = 3'(READY_WAIT_CYC);

  // controller clock divider off the cpu clock
  localparam int unsigned CPU_CLOCK_KHZ   = 266000;
  localparam int unsigned CTRL_MAX_KHZ    = 66000;
  localparam int unsigned DIV_WIDTH       = 5;
  localparam logic [4:0]  DIV_RESET       = 5'h10;
  localparam logic [4:0]  DIV_MIN         =
    5'((CPU_CLOCK_KHZ + CTRL_MAX_KHZ - 1) / CTRL_MAX_KHZ);

  // command kinds on the request port
  typedef enum logic [1:0] {
    KIND_COMMAND = 2'b00,
    KIND_ADDRESS = 2'b01,
    KIND_WRITE   = 2'b10,
    KIND_READ    = 2'b11
  } kind_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_SETUP = 4'b0001,
    ST_WLOW  = 4'b0010,
    ST_WHOLD = 4'b0011,
    ST_RWAIT = 4'b0100,
    ST_RLOW1 = 4'b0101,
    ST_RLOW2 = 4'b0110,
    ST_RHIGH = 4'b0111,
    ST_RTAIL = 4'b1000
  } state_t;

endpackage
`default_nettype wire

/* nand_strobe_asserts.sv */
// pin timing checker for the nand strobe sequencer
// assumes it is bound to the sequencer top module and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module nand_strobe_asserts
  import nand_strobe_pkg::*;
#(
  parameter int unsigned DATA_WIDTH = 8
) (
  // clock and reset
  input wire logic                  MCLK,
  input wire logic                  RESET,
  // divider
  input wire logic                  DIV_LOAD,
  input wire logic [DIV_WIDTH-1:0]  DIV_VALUE,
  input wire logic [DIV_WIDTH-1:0]  FLASH_CLOCK_DIVIDER,
  // flash pins
  input wire logic                  COMMAND_LATCH_EN,
  input wire logic                  ADDRESS_LATCH_EN,
  input wire logic                  FLASH_CHIP_SELECT_N,
  input wire logic                  FLASH_WRITE_STROBE_N,
  input wire logic                  FLASH_READ_STROBE_N,
  input wire logic                  FLASH_READY,
  input wire logic [DATA_WIDTH-1:0] FLASH_DQ_OUT,
  input wire logic                  FLASH_DQ_OE_N
);
  wire  we_n = FLASH_WRITE_STROBE_N;
  wire  re_n = FLASH_READ_STROBE_N;
  wire  cs_n = FLASH_CHIP_SELECT_N;
  wire  cle  = COMMAND_LATCH_EN;
  wire  ale  = ADDRESS_LATCH_EN;
  logic rst_q;

  // a reset in mid transfer snaps the pins idle one edge later; that jump is
  // no strobe edge, so the checks stay off for one more edge
  always_ff @(posedge MCLK) begin
    rst_q <= RESET;
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET || rst_q);

  property p_cle; $rose(we_n) |-> $stable(cle) && cle == $past(cle, 2); endproperty
  a_cle: assert property (p_cle) else $error("command latch moved around write strobe");
  property p_ale; $rose(we_n) |-> $stable(ale) && ale == $past(ale, 2); endproperty
  a_ale: assert property (p_ale) else $error("address latch moved around write strobe");
  property p_cs_set; $fell(we_n) || $fell(re_n) |-> !$past(cs_n); endproperty
  a_cs_set: assert property (p_cs_set) else $error("strobe fell without chip select lead");
  // the read strobe moves on the falling edge, so a full period back is two samples
  property p_cs_hold; $rose(cs_n) |-> $past(we_n) && $past(re_n) && $past(re_n, 2); endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("chip select released too early");
  property p_wdata; $rose(we_n) |-> $stable(FLASH_DQ_OUT) && !FLASH_DQ_OE_N; endproperty
  a_wdata: assert property (p_wdata) else $error("write data not held over strobe");
  // ready must have stood at the last five edges of the wait, so a busy gap there shows here
  property p_rwait;
    $fell(re_n) |-> $past(FLASH_READY) && $past(FLASH_READY, 2) && $past(FLASH_READY, 3) &&
      $past(FLASH_READY, 4) && $past(FLASH_READY, 5);
  endproperty
  a_rwait: assert property (p_rwait) else $error("read strobe too soon after ready");
  property p_re_low; $fell(re_n) |=> !re_n; endproperty
  a_re_low: assert property (p_re_low) else $error("read strobe pulse too short");
  property p_re_high; $rose(re_n) |=> re_n; endproperty
  a_re_high: assert property (p_re_high) else $error("read strobe high time too short");
  property p_div;
    DIV_LOAD |=> FLASH_CLOCK_DIVIDER == ($past(DIV_VALUE) < DIV_MIN ? DIV_MIN : $past(DIV_VALUE));
  endproperty
  a_div: assert property (p_div) else $error("divider setting wrong after load");
  property p_rst;
    disable iff (1'b0) RESET |=> !cle && !ale && cs_n && we_n && re_n && FLASH_CLOCK_DIVIDER == DIV_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not idle in reset");

  c_cmd: cover property ($rose(we_n) && cle);
  c_read: cover property ($fell(re_n));
  c_load: cover property (DIV_LOAD);
endmodule
`default_nettype wire

/* nand_flash_model.sv */
// behavioural nand flash facing the strobe sequencer
// assumes pins other than re_n change on clk rising edges; slow gives long busy and late data
`timescale 1ns/1ns
`default_nettype none
module nand_flash_model (
  // clock
  input wire logic       clk,
  // pins from the sequencer
  input wire logic       cs_n,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       we_n,
  input wire logic       re_n,
  input wire logic [7:0] dq_out,
  // mode from the bench and answers
  input wire logic       slow,
  output logic           ready,
  output logic     [7:0] dq_in
);
  logic [7:0] mem [0:15];
  logic       we_q = 1'b1;
  logic [3:0] wp = 4'h0;
  logic [3:0] rp = 4'h0;
  int         busy = 0;

  assign ready = (busy == 0);
  initial dq_in = 8'h00;

  always @(posedge clk) begin
    we_q <= we_n;
    if (busy > 0) busy <= busy - 1;
    if (!we_q && we_n && !cs_n) begin
      if (cle) begin
        busy <= slow ? 9 : 2;
        rp <= 4'h0;
      end else if (!ale) begin
        mem[wp] <= dq_out;
        wp <= wp + 4'h1;
      end
    end
  end

  // late data in slow mode still leaves 20 ns before the sample point
  always @(negedge re_n) begin
    dq_in = ~dq_in;
    #(slow ? 130 : 20) dq_in = mem[rp];
  end
  // data is not held past the strobe rise
  always @(posedge re_n) begin
    rp = rp + 4'h1;
    dq_in = ~dq_in;
  end
endmodule
`default_nettype wire

/* test_nand_flash_strobe_timing.sv */
// self-checking bench for the nand strobe sequencer with a flash model
// assumes the checker and flash model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module test_nand_flash_strobe_timing
  import nand_strobe_pkg::*;
;
  logic mclk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, rd_ready = 1'b0, div_load = 1'b0, slow = 1'b0;
  logic [1:0] cmd_kind = 2'h0;
  logic [7:0] cmd_data = 8'h00;
  logic [4:0] div_value = 5'h00;
  logic cmd_ready, rd_valid, cle, ale, cs_n, we_n, re_n, ready, oe_n;
  logic [7:0] rd_data, dq_in, dq_out;
  logic [4:0] divider;
  int error_cnt = 0;
  int comparisons = 0;
  realtime we_fall = 0;

  always #50 mclk = ~mclk;

  nand_flash_strobe_timing DUT (.MCLK(mclk), .RESET(reset), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_KIND(cmd_kind), .CMD_DATA(cmd_data), .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data),
    .DIV_LOAD(div_load), .DIV_VALUE(div_value), .FLASH_CLOCK_DIVIDER(divider), .COMMAND_LATCH_EN(cle),
    .ADDRESS_LATCH_EN(ale), .FLASH_CHIP_SELECT_N(cs_n), .FLASH_WRITE_STROBE_N(we_n),
    .FLASH_READ_STROBE_N(re_n), .FLASH_READY(ready), .FLASH_DQ_IN(dq_in), .FLASH_DQ_OUT(dq_out),
    .FLASH_DQ_OE_N(oe_n));
  nand_flash_model flash (.clk(mclk), .cs_n(cs_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .dq_out(dq_out), .slow(slow), .ready(ready), .dq_in(dq_in));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // leaves the request up; the caller lowers it
  task automatic send(input kind_t k, input logic [7:0] d);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_data <= d;
    @(posedge mclk);
    for (int i = 0; i < 60 && cmd_ready !== 1'b1; i++) @(posedge mclk);
    check(cmd_ready, 1'b1);
  endtask
  task automatic get(input logic [7:0] exp);
    rd_ready <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 80 && rd_valid !== 1'b1; i++) @(posedge mclk);
    check(rd_data, exp);
  endtask
  task automatic check_idle;
    check({2'b00, cle, ale, cs_n, we_n, re_n, oe_n}, 8'h0F);
  endtask

  // a write cycle shorter than two periods shows here
  always @(negedge we_n) begin
    if (we_fall > 0) check($realtime - we_fall >= 200.0, 8'h01);
    we_fall = $realtime;
  end

  task automatic t_div;
    logic [4:0] v [3] = '{5'h03, 5'h0C, 5'h08};
    foreach (v[i]) begin
      div_load <= 1'b1;
      div_value <= v[i];
      @(posedge mclk);
      div_load <= 1'b0;
      @(posedge mclk);
      check(divider, v[i] < DIV_MIN ? DIV_MIN : v[i]);
    end
  endtask
  task automatic t_write;
    send(KIND_COMMAND, 8'h80);
    send(KIND_ADDRESS, 8'h05);
    send(KIND_WRITE, 8'hA5);
    send(KIND_WRITE, 8'h3C);
    send(KIND_WRITE, 8'hC3);
    cmd_valid <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic t_read;
    logic [7:0] e [3] = '{8'hA5, 8'h3C, 8'hC3};
    send(KIND_COMMAND, 8'h00);
    foreach (e[i]) begin
      send(KIND_READ, 8'h00);
      cmd_valid <= 1'b0;
      get(e[i]);
      rd_ready <= 1'b0;
    end
    @(posedge mclk);
  endtask
  // consumer stalls until both buffer entries fill and a third read waits
  task automatic t_stall;
    slow <= 1'b1;
    send(KIND_COMMAND, 8'h00);
    send(KIND_READ, 8'h00);
    send(KIND_READ, 8'h00);
    repeat (30) @(posedge mclk);
    check({cmd_ready, rd_valid}, 8'h01);
    get(8'hA5);
    rd_ready <= 1'b0;
    send(KIND_READ, 8'h00);
    cmd_valid <= 1'b0;
    get(8'h3C);
    get(8'hC3);
    rd_ready <= 1'b0;
    @(posedge mclk);
    check(rd_valid, 1'b0);
  endtask
  task automatic t_rstmid;
    send(KIND_COMMAND, 8'h90);
    cmd_valid <= 1'b0;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    check_idle;
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    check(cmd_ready, 1'b1);
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    check_idle;
    check(divider, DIV_RESET);
    reset <= 1'b0;
    @(posedge mclk);
    t_div;
    t_write;
    t_read;
    t_stall;
    t_rstmid;
    complete_run;
  end
  initial begin
    #(3000 * 100);
    error_cnt++;
    complete_run;
  end
endmodule
bind nand_flash_strobe_timing nand_strobe_asserts #(.DATA_WIDTH(DATA_WIDTH)) chk (.MCLK(MCLK), .RESET(RESET),
  .DIV_LOAD(DIV_LOAD),
  .DIV_VALUE(DIV_VALUE), .FLASH_CLOCK_DIVIDER(FLASH_CLOCK_DIVIDER), .COMMAND_LATCH_EN(COMMAND_LATCH_EN),
  .ADDRESS_LATCH_EN(ADDRESS_LATCH_EN), .FLASH_CHIP_SELECT_N(FLASH_CHIP_SELECT_N),
  .FLASH_WRITE_STROBE_N(FLASH_WRITE_STROBE_N), .FLASH_READ_STROBE_N(FLASH_READ_STROBE_N),
  .FLASH_READY(FLASH_READY), .FLASH_DQ_OUT(FLASH_DQ_OUT), .FLASH_DQ_OE_N(FLASH_DQ_OE_N));
`default_nettype wire
